// ==== verilog/ise_exec.sv ====
// executor for six core instructions: subtract, table read, timer mode, exclusive-or
`timescale 1ns/1ps
`default_nettype none
module ise_exec (
  input  wire logic                          clock,
  input  wire logic                          reset,
  input  wire logic                          clock_enable,
  input  wire logic                          op_valid,
  input  wire ise_pkg::ise_op_t              op_code,
  input  wire logic [7:0]                    immediate,
  input  wire logic [7:0]                    file_data,
  input  wire logic                          dest_bit,
  input  wire logic [ise_pkg::PAGE_W-1:0]    table_page_pointer,
  input  wire logic [ise_pkg::ROM_W-1:0]     rom_data,
  output logic                               op_ready,
  output logic                               rom_rd,
  output logic [ise_pkg::ROM_ADDR_W-1:0]     rom_addr,
  output logic [7:0]                         work_register,
  output logic [7:0]                         timer_mode_register,
  output logic [ise_pkg::HIGH_W-1:0]         table_high_byte,
  output logic                               zero_flag,
  output logic                               half_carry_flag,
  output logic                               carry_flag,
  output logic                               file_wr_en,
  output logic [7:0]                         file_wr_data,
  output logic                               op_done
);
  import ise_pkg::*;

  typedef enum logic {st_exec, st_table} ise_state_t;

  ise_state_t state;
  logic       take;
  ise_alu_if  alu_bus ();

  ise_alu u_alu (
    .bus (alu_bus.alu)
  );

  // operand is the immediate except for the file exclusive-or
  assign alu_bus.op      = op_code;
  assign alu_bus.work    = work_register;
  assign alu_bus.operand = (op_code == xor_with_file_op) ? file_data : immediate;

  // a new operation is accepted only in the execute state
  assign op_ready = (state == st_exec);
  assign rom_rd   = (state == st_table);
  assign take     = op_valid && op_ready && clock_enable;

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= st_exec;
    end else if (clock_enable) begin
      case (state)
        st_exec:  state <= (take && op_code == rom_lookup_op) ? st_table : st_exec;
        st_table: state <= st_exec;
        default:  state <= st_exec;
      endcase
    end
  end

  // page pointer bits above work register; held for the second cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      rom_addr <= ROM_ADDR_RST;
    end else if (take && op_code == rom_lookup_op) begin
      rom_addr <= {table_page_pointer[PAGE_BITS-1:0], work_register};
    end
  end

  // work register: every writer lives here so there is one driver
  always_ff @(posedge clock) begin
    if (reset) begin
      work_register <= WORK_RST;
    end else if (clock_enable) begin
      if (state == st_table) begin
        // low word byte to work register
        work_register <= rom_data[LOW_MSB:0];
      end else if (take) begin
        case (op_code)
          sub_from_immediate_op: work_register <= alu_bus.result;
          read_timer_mode_op:    work_register <= timer_mode_register;
          xor_with_file_op:      if (!dest_bit) work_register <= alu_bus.result;
          xor_immediate_op:      work_register <= alu_bus.result;
          default:               work_register <= work_register;
        endcase
      end
    end
  end

  // timer mode load from work register
  always_ff @(posedge clock) begin
    if (reset) begin
      timer_mode_register <= TMODE_RST;
    end else if (take && op_code == load_timer_mode_op) begin
      timer_mode_register <= work_register;
    end
  end

  // upper six word bits captured in the second cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      table_high_byte <= HIGH_RST;
    end else if (clock_enable && state == st_table) begin
      table_high_byte <= rom_data[ROM_W-1:HIGH_LSB];
    end
  end

  // status flags: subtract touches three, exclusive-or only zero
  always_ff @(posedge clock) begin
    if (reset) begin
      zero_flag       <= FLAG_RST;
      half_carry_flag <= FLAG_RST;
      carry_flag      <= FLAG_RST;
    end else if (take) begin
      case (op_code)
        sub_from_immediate_op: begin
          zero_flag       <= alu_bus.zero;
          half_carry_flag <= alu_bus.half_carry;
          carry_flag      <= alu_bus.carry;
        end
        xor_with_file_op: zero_flag <= alu_bus.zero;
        xor_immediate_op: zero_flag <= alu_bus.zero;
        default: zero_flag <= zero_flag;
      endcase
    end
  end

  // file write-back pulse; stretches while the clock enable is low since state freezes
  always_ff @(posedge clock) begin
    if (reset) begin
      file_wr_en   <= 1'b0;
      file_wr_data <= 8'h00;
    end else if (clock_enable) begin
      // destination 1 writes the file register
      file_wr_en <= take && op_code == xor_with_file_op && dest_bit;
      if (take && op_code == xor_with_file_op) begin
        file_wr_data <= alu_bus.result;
      end
    end
  end

  // completion pulse: single-cycle ops at once, table read after its second cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      op_done <= 1'b0;
    end else if (clock_enable) begin
      op_done <= (take && op_code != rom_lookup_op) || state == st_table;
    end
  end

  // checks: results tied to their causes
  property p_sub_result;
    @(posedge clock) disable iff (reset)
    take && op_code == sub_from_immediate_op |=>
      work_register == 8'($past(immediate) - $past(work_register));
  endproperty
  a_sub_result: assert property (p_sub_result) else $error("subtract result wrong");

  property p_sub_flags;
    @(posedge clock) disable iff (reset)
    take && op_code == sub_from_immediate_op |=>
      carry_flag == ($past(immediate) >= $past(work_register)) &&
      zero_flag == (work_register == 8'h00);
  endproperty
  a_sub_flags: assert property (p_sub_flags) else $error("subtract flags wrong");

  property p_rom_addr;
    @(posedge clock) disable iff (reset)
    take && op_code == rom_lookup_op |=>
      rom_rd && rom_addr == {$past(table_page_pointer[2:0]), $past(work_register)};
  endproperty
  a_rom_addr: assert property (p_rom_addr) else $error("table address wrong");

  property p_tbl_low;
    @(posedge clock) disable iff (reset)
    state == st_table && clock_enable |=> work_register == $past(rom_data[7:0]);
  endproperty
  a_tbl_low: assert property (p_tbl_low) else $error("table low byte wrong");

  property p_tbl_high;
    @(posedge clock) disable iff (reset)
    state == st_table && clock_enable |=>
      table_high_byte == $past(rom_data[13:8]) && $stable(zero_flag) && $stable(carry_flag);
  endproperty
  a_tbl_high: assert property (p_tbl_high) else $error("table high bits wrong");

  property p_tmode_load;
    @(posedge clock) disable iff (reset)
    take && op_code == load_timer_mode_op |=>
      timer_mode_register == $past(work_register) && $stable(zero_flag);
  endproperty
  a_tmode_load: assert property (p_tmode_load) else $error("timer mode load wrong");

  property p_tmode_read;
    @(posedge clock) disable iff (reset)
    take && op_code == read_timer_mode_op |=>
      work_register == $past(timer_mode_register) && $stable(timer_mode_register);
  endproperty
  a_tmode_read: assert property (p_tmode_read) else $error("timer mode read wrong");

  property p_xor_file;
    @(posedge clock) disable iff (reset)
    take && op_code == xor_with_file_op && dest_bit |=>
      file_wr_en && file_wr_data == ($past(file_data) ^ $past(work_register)) &&
      $stable(work_register);
  endproperty
  a_xor_file: assert property (p_xor_file) else $error("file xor write-back wrong");

  property p_xor_imm;
    @(posedge clock) disable iff (reset)
    take && op_code == xor_immediate_op |=>
      work_register == ($past(immediate) ^ $past(work_register)) && $stable(carry_flag);
  endproperty
  a_xor_imm: assert property (p_xor_imm) else $error("immediate xor wrong");

  property p_table_two;
    @(posedge clock) disable iff (reset)
    take && op_code == rom_lookup_op |=> !op_ready ##1 (op_ready || !$past(clock_enable));
  endproperty
  a_table_two: assert property (p_table_two) else $error("table read length wrong");

  property p_single_one;
    @(posedge clock) disable iff (reset)
    take && op_code != rom_lookup_op |=> op_ready && op_done;
  endproperty
  a_single_one: assert property (p_single_one) else $error("single op stalled");

  // main scenarios
  c_sub_borrow: cover property (@(posedge clock) disable iff (reset)
    take && op_code == sub_from_immediate_op && immediate < work_register);
  c_table_read: cover property (@(posedge clock) disable iff (reset)
    take && op_code == rom_lookup_op ##2 op_done);
  c_xor_file: cover property (@(posedge clock) disable iff (reset)
    take && op_code == xor_with_file_op && dest_bit);
  c_back_to_back: cover property (@(posedge clock) disable iff (reset)
    take ##1 take);
endmodule // ise_exec
`default_nettype wire

// ==== inc/ise_pkg.sv ====
// shared constants, opcode type and helpers for the instruction subset executor
`default_nettype none
package ise_pkg;
  localparam int DATA_W     = 8;   // work register and file data width
  localparam int ROM_W      = 14;  // program word width
  localparam int PAGE_BITS  = 3;   // page pointer bits used in a table address
  localparam int PAGE_W     = 8;   // full page pointer register width
  localparam int HIGH_W     = 6;   // upper program word bits kept in table_high_byte
  localparam int ROM_ADDR_W = PAGE_BITS + DATA_W;
  localparam int LOW_MSB    = 7;   // low byte of a program word is [7:0]
  localparam int HIGH_LSB   = 8;   // upper part of a program word is [13:8]
  localparam int TABLE_CYCLES = 2; // table read occupies two instruction cycles
  localparam int SINGLE_CYCLES = 1;

  localparam logic [7:0]  WORK_RST   = 8'h00;
  localparam logic [7:0]  TMODE_RST  = 8'h00;
  localparam logic [5:0]  HIGH_RST   = 6'h00;
  localparam logic [10:0] ROM_ADDR_RST = 11'h000;
  localparam logic        FLAG_RST   = 1'b0;

  // the six operations this block executes
  typedef enum logic [2:0] {
    sub_from_immediate_op,
    rom_lookup_op,
    load_timer_mode_op,
    read_timer_mode_op,
    xor_with_file_op,
    xor_immediate_op
  } ise_op_t;

  // zero detect, used by the alu for its zero output
  function automatic logic ise_is_zero(input logic [7:0] value);
    return value == 8'h00;
  endfunction
endpackage : ise_pkg
`default_nettype wire

// ==== inc/ise_alu_if.sv ====
// carrier between the executor and its arithmetic unit
`timescale 1ns/1ps
`default_nettype none
interface ise_alu_if;
  import ise_pkg::*;
  ise_op_t          op;
  logic [7:0]       work;
  logic [7:0]       operand;
  logic [7:0]       result;
  logic             zero;
  logic             half_carry;
  logic             carry;
  modport exec (output op, work, operand, input result, zero, half_carry, carry);
  modport alu  (input op, work, operand, output result, zero, half_carry, carry);
endinterface : ise_alu_if
`default_nettype wire

// ==== verilog/ise_alu.sv ====
// combinational subtract and exclusive-or unit
`timescale 1ns/1ps
`default_nettype none
module ise_alu (
  ise_alu_if.alu bus
);
  import ise_pkg::*;

  logic [8:0] sum9;
  logic [4:0] nib5;

  // operand minus work as operand + ~work + 1, carry high means no borrow
  always_comb begin
    sum9 = {1'b0, bus.operand} + {1'b0, ~bus.work} + 9'h001;
    nib5 = {1'b0, bus.operand[3:0]} + {1'b0, ~bus.work[3:0]} + 5'h01;
    case (bus.op)
      sub_from_immediate_op: bus.result = sum9[7:0];
      xor_with_file_op,
      xor_immediate_op:      bus.result = bus.work ^ bus.operand;
      default:               bus.result = bus.operand;
    endcase
    bus.zero       = ise_is_zero(bus.result);
    bus.half_carry = nib5[4];
    bus.carry      = sum9[8];
  end
endmodule // ise_alu
`default_nettype wire

// ==== verification/tb_insn_subset_exec.sv ====
// self-checking testbench for the instruction subset executor
`timescale 1ns/1ps
`default_nettype none
module tb_insn_subset_exec;
  import ise_pkg::*;
  logic                  clock = 1'b0;
  logic                  reset = 1'b1;
  logic                  clock_enable = 1'b1;
  logic                  op_valid = 1'b0;
  ise_op_t               op_code = xor_immediate_op;
  logic [7:0]            immediate = 8'h00;
  logic [7:0]            file_data = 8'h00;
  logic                  dest_bit = 1'b0;
  logic [PAGE_W-1:0]     table_page_pointer = 8'h00;
  logic [ROM_W-1:0]      rom_data = 14'h0000;
  logic                  op_ready, rom_rd, zero_flag, half_carry_flag, carry_flag;
  logic                  file_wr_en, op_done;
  logic [ROM_ADDR_W-1:0] rom_addr;
  logic [7:0]            work_register, timer_mode_register, file_wr_data;
  logic [HIGH_W-1:0]     table_high_byte;
  logic [7:0]            w;
  int                    failures = 0;
  int                    total_checks = 0;

  ise_exec DUT (.clock(clock), .reset(reset), .clock_enable(clock_enable),
    .op_valid(op_valid), .op_code(op_code), .immediate(immediate), .file_data(file_data),
    .dest_bit(dest_bit), .table_page_pointer(table_page_pointer), .rom_data(rom_data),
    .op_ready(op_ready), .rom_rd(rom_rd), .rom_addr(rom_addr), .work_register(work_register),
    .timer_mode_register(timer_mode_register), .table_high_byte(table_high_byte),
    .zero_flag(zero_flag), .half_carry_flag(half_carry_flag), .carry_flag(carry_flag),
    .file_wr_en(file_wr_en), .file_wr_data(file_wr_data), .op_done(op_done));

  // 100 MHz instruction clock
  always #5 clock = ~clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] expected, input string what);
    total_checks++;
    if (seen !== expected) begin
      failures++;
      $display("[FAIL] %0t ns %s: seen %h expected %h", $time, what, seen, expected);
    end
  endtask

  // present one op and return just after its take edge
  task automatic issue(input ise_op_t op, input logic [7:0] imm, input logic [7:0] fd,
                       input logic dest);
    @(posedge clock);
    op_valid  <= 1'b1;
    op_code   <= op;
    immediate <= imm;
    file_data <= fd;
    dest_bit  <= dest;
    @(posedge clock);
    op_valid  <= 1'b0;
    #1;
  endtask

  task automatic t_xor_imm();
    logic [7:0] k [3] = '{8'ha5, 8'ha5, 8'h06};
    foreach (k[i]) begin
      issue(xor_immediate_op, k[i], 8'h00, 1'b0);
      w = w ^ k[i];
      check(work_register, w, "xor imm result");
      check(zero_flag, w == 8'h00, "xor imm zero");
      check({half_carry_flag, carry_flag}, 2'b00, "xor imm other flags");
      check(op_done, 1'b1, "xor imm one cycle");
    end
    $display("test xor immediate done");
  endtask

  task automatic t_sub();
    logic [7:0] k [5] = '{8'h05, 8'h00, 8'h01, 8'h10, 8'h0f};
    foreach (k[i]) begin
      issue(sub_from_immediate_op, k[i], 8'h00, 1'b0);
      check(carry_flag, k[i] >= w, "sub carry");
      check(half_carry_flag, k[i][3:0] >= w[3:0], "sub half carry");
      w = k[i] - w;
      check(work_register, w, "sub result");
      check(zero_flag, w == 8'h00, "sub zero");
      check(op_done, 1'b1, "sub one cycle");
    end
    $display("test subtract done");
  endtask

  task automatic t_timer();
    issue(load_timer_mode_op, 8'h00, 8'h00, 1'b0);
    check(timer_mode_register, w, "mode load");
    check({zero_flag, half_carry_flag, carry_flag}, 3'b010, "mode load flags");
    issue(xor_immediate_op, 8'h0f, 8'h00, 1'b0);
    issue(read_timer_mode_op, 8'h00, 8'h00, 1'b0);
    check(work_register, w, "mode read");
    check(timer_mode_register, w, "mode kept");
    check({half_carry_flag, carry_flag, op_done}, 3'b101, "mode read flags");
    $display("test timer mode done");
  endtask

  task automatic t_table();
    issue(xor_immediate_op, 8'hcb, 8'h00, 1'b0);
    // pointer and word change on an edge, like every other input
    @(posedge clock);
    table_page_pointer <= 8'hfa;
    rom_data           <= 14'h35aa;
    issue(rom_lookup_op, 8'h00, 8'h00, 1'b0);
    check(rom_addr, 11'h234, "table address");
    check({rom_rd, op_ready, op_done}, 3'b100, "table second cycle");
    @(posedge clock);
    #1;
    check(work_register, 8'haa, "table low bits");
    check(table_high_byte, 6'h35, "table high bits");
    check({zero_flag, half_carry_flag, carry_flag}, 3'b010, "table flags");
    check({op_done, op_ready, rom_rd}, 3'b110, "table two cycles");
    w = 8'haa;
    $display("test table read done");
  endtask

  task automatic t_xor_file();
    issue(xor_with_file_op, 8'h00, 8'h5f, 1'b1);
    check({file_wr_en, file_wr_data}, {1'b1, 8'hf5}, "xor file write");
    check({work_register, zero_flag}, {w, 1'b0}, "xor file keeps work");
    issue(xor_with_file_op, 8'h00, 8'haa, 1'b0);
    check({file_wr_en, work_register, zero_flag}, {1'b0, 8'h00, 1'b1}, "xor to work");
    // a frozen core must not take the pending op
    @(posedge clock);
    clock_enable <= 1'b0;
    op_valid     <= 1'b1;
    op_code      <= xor_immediate_op;
    immediate    <= 8'h3c;
    repeat (2) @(posedge clock);
    #1;
    check({work_register, op_done}, 9'h000, "frozen no take");
    @(posedge clock);
    clock_enable <= 1'b1;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
    check(work_register, 8'h3c, "taken after enable");
    $display("test xor file done");
  endtask

  // ops on consecutive edges; a file op held through the table second cycle
  // must be refused there, else it would pulse the file write early
  task automatic t_back_to_back();
    @(posedge clock);
    op_valid  <= 1'b1;
    op_code   <= xor_immediate_op;
    immediate <= 8'h0f;
    @(posedge clock);
    op_code   <= sub_from_immediate_op;
    immediate <= 8'h40;
    #1;
    check(work_register, 8'h33, "b2b xor");
    @(posedge clock);
    op_code   <= rom_lookup_op;
    #1;
    check({work_register, carry_flag, half_carry_flag, zero_flag}, {8'h0d, 3'b100}, "b2b sub");
    @(posedge clock);
    op_code   <= xor_with_file_op;
    file_data <= 8'h0f;
    dest_bit  <= 1'b1;
    #1;
    check({rom_addr, rom_rd, op_ready}, {11'h20d, 2'b10}, "b2b table address");
    @(posedge clock);
    #1;
    check({work_register, file_wr_en, op_ready, op_done}, {8'haa, 3'b011}, "b2b held refused");
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
    check({file_wr_en, file_wr_data}, {1'b1, 8'ha5}, "b2b taken after table");
    check({work_register, table_high_byte}, {8'haa, 6'h35}, "b2b table kept");
    $display("test back to back done");
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog at 2000 cycles, well past the under one hundred cycles the tests need
  initial begin
    #20000;
    failures++;
    results();
  end

  initial begin
    w = WORK_RST;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    #1;
    check({work_register, zero_flag, op_ready, op_done}, 11'h002, "reset values");
    t_xor_imm();
    t_sub();
    t_timer();
    t_table();
    t_xor_file();
    t_back_to_back();
    results();
  end
endmodule // tb_insn_subset_exec
`default_nettype wire
